// File: bench/p4t_link_model.sv
// Purpose: Behavioural source of the serial path stream
// Assumes: Link clock stands still while idle
// Notes:   A bad frame sends the inverted multiframe code
`default_nettype none
module p4t_link_model #(
  parameter int FRAME_BITS = 32,
  parameter int OH_POS     = 16
) (
  // Control
  input  wire logic       run,
  input  wire logic       badMf,
  input  wire logic [2:0] lbl,
  // Serial stream
  output logic            p4sClk,
  output logic            p4sData,
  output logic            p4sFrameStart
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] code;
  logic [7:0] oh;
  // Data moves on the falling edge; the idle offset keeps link edges
  // clear of sys_clk edges
  initial begin
    p4sClk = 1'h0;
    p4sData = 1'h0;
    p4sFrameStart = 1'h0;
    code = 2'h0;
    forever begin
      if (!run) begin
        p4sData = ~p4sData;
        wait (run);
        #1.3;
      end
      code = code + 2'h1;
      oh = {2'($urandom), lbl, badMf ? ~code : code, 1'($urandom)};
      for (int i = 0; i < FRAME_BITS; i++) begin
        p4sFrameStart = (i == 0);
        p4sData = (i >= OH_POS && i < OH_POS + 8) ?
                  oh[OH_POS + 7 - i] : 1'($urandom);
        #32 p4sClk = 1'h1;
        #32 p4sClk = 1'h0;
      end
    end
  end
endmodule : p4t_link_model
`default_nettype wire

// File: bench/p4t_sink_properties.sv
// Purpose: Port-level properties of the TUG-3 sink adaptation
// Assumes: One sys_clk domain, srst synchronous
// Notes:   Loss timing is judged against the last multiframe start
`default_nettype none
module p4t_sink_properties #(
  parameter int LOM_CNT = 2000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Stream
  input wire logic p4sData,
  input wire logic tug3Data,
  input wire logic tug3FrameStart,
  input wire logic multiframeStartOut,
  input wire logic tu3ServerFailOut,
  input wire logic tug2ServerFailOut,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  int upCnt;
  int sinceMfs;
  // Warm-up count hides the sync pipeline flush after reset
  always_ff @(posedge sys_clk) begin
    if (srst) upCnt <= 0;
    else if (upCnt < 8) upCnt <= upCnt + 1;
    if (srst || multiframeStartOut) sinceMfs <= 0;
    else if (sinceMfs < LOM_CNT) sinceMfs <= sinceMfs + 1;
  end
  a_pass_data: assert property (
    upCnt > 3 |-> tug3Data == $past(p4sData, 3))
    else $error("stream data not passed on");
  a_fail_reset: assert property (
    $fell(srst) |-> tu3ServerFailOut && tug2ServerFailOut)
    else $error("fail outputs low after reset");
  a_fail_nest: assert property (
    tu3ServerFailOut |-> tug2ServerFailOut)
    else $error("tu3 fail without tug2 fail");
  a_mfs_pulse: assert property (
    multiframeStartOut |-> tug3FrameStart ##1 !multiframeStartOut)
    else $error("multiframe start misplaced");
  a_lom_time: assert property (
    $rose(tug2ServerFailOut) && !tu3ServerFailOut |-> sinceMfs >= LOM_CNT)
    else $error("loss declared too early");
  a_lom_clear: assert property (
    multiframeStartOut && !tu3ServerFailOut |-> !tug2ServerFailOut)
    else $error("loss held while aligned");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing");
  a_wr_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
endmodule : p4t_sink_properties
`default_nettype wire

// File: bench/test_p4t_tug3_adaptation_sink.sv
// Purpose: Self-checking bench for the TUG-3 sink adaptation
// Assumes: Short frames and a short loss time keep the run brief
// Notes:   Expected values come from bench functions and literal constants
`default_nettype none
`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_p4t_tug3_adaptation_sink;
  timeunit 1ns;
  timeprecision 100ps;
  import p4t_pkg::*;
  localparam int LOM = 3000;
  logic sys_clk = 1'h0, srst = 1'h1, incomingTrailFail = 1'h0;
  logic p4sClk, p4sData, p4sFrameStart, tug3Clk, tug3Data;
  logic tug3FrameStart, multiframeStartOut, loSinkValid, irq;
  logic tu3ServerFailOut, tug2ServerFailOut;
  logic [1:0] loSinkTug3, loSinkTu12, s_axi_bresp, s_axi_rresp;
  logic [2:0] loSinkTug2, lbl = 3'h4;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, run = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, badMf = 1'h0;
  int err_total = 0, n_tests = 0, cyc = 0, mfsCnt = 0;

  p4t_tug3_adaptation_sink #(.LOM_CNT(LOM)) i_dut (.sys_clk, .srst,
    .p4sClk, .p4sData, .p4sFrameStart, .incomingTrailFail, .tug3Clk,
    .tug3Data, .tug3FrameStart, .multiframeStartOut, .tu3ServerFailOut,
    .tug2ServerFailOut, .loSinkTug3, .loSinkTug2, .loSinkTu12,
    .loSinkValid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);
  p4t_link_model i_link (.run, .badMf, .lbl, .p4sClk, .p4sData,
    .p4sFrameStart);

  always #2.5 sys_clk = ~sys_clk;
  // Cycle ceiling cuts a hang short; start pulses are tallied
  always @(posedge sys_clk) begin
    cyc++;
    mfsCnt += multiframeStartOut;
    if (cyc == 80000) begin
      err_total++;
      end_sim();
    end
  end

  function automatic logic [31:0] st(logic p, logic l, logic i,
                                      logic [2:0] lb);
    return {25'h0, lb, 1'h0, i, l, p};
  endfunction : st
  function automatic logic ok3(logic [1:0] k, logic [2:0] l,
                               logic [1:0] m);
    return k != 2'h3 && l != 3'h0 && m != 2'h0 && (k != TUG3_C || l < 3'h6);
  endfunction : ok3

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // Each channel is released at its own handshake edge
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(nm, e, d)
  endtask : rdc
  task automatic frm(int n);
    repeat (n) @(posedge p4sFrameStart);
  endtask : frm
  // Let registered outputs land before looking at them
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    logic [31:0] d;
    logic [1:0] r, k, m;
    logic [2:0] l;
    void'($urandom(45911));
    repeat (10) @(posedge sys_clk);
    srst <= 1'h0;
    `CHK("tu3 rst", 1'h1, tu3ServerFailOut)
    `CHK("tug2 rst", 1'h1, tug2ServerFailOut)
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("mask", ADDR_IRQ_MASK, 32'h0);
    rdc("st idle", ADDR_STATUS, 32'h0);
    rd(8'h20, d, r);
    `CHK("bad rd", RESP_SLVERR, r)
    wr(8'h20, 32'h1, RESP_SLVERR);
    $display("test reset done");
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
    run <= 1'h1;
    frm(8);
    mfsCnt = 0;
    frm(8);
    `CHK("mf starts", 2, mfsCnt)
    rdc("st ok", ADDR_STATUS, st(0, 0, 1, 3'h4));
    `CHK("tu3 ok", 1'h0, tu3ServerFailOut)
    `CHK("tug2 ok", 1'h0, tug2ServerFailOut)
    wr(ADDR_IRQ_STAT, 32'h3, RESP_OKAY);
    badMf <= 1'h1;
    frm(1);
    badMf <= 1'h0;
    frm(1);
    rdc("oom", ADDR_STATUS, st(0, 0, 0, 3'h4));
    frm(3);
    rdc("not yet", ADDR_STATUS, st(0, 0, 0, 3'h4));
    frm(3);
    rdc("realign", ADDR_STATUS, st(0, 0, 1, 3'h4));
    $display("test align done");
    badMf <= 1'h1;
    frm(11);
    `CHK("tu3 lom", 1'h0, tu3ServerFailOut)
    `CHK("tug2 lom", 1'h1, tug2ServerFailOut)
    `CHK("irq", 1'h1, irq)
    rdc("lom st", ADDR_STATUS, st(0, 1, 0, 3'h4));
    rdc("irq st", ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    settle();
    `CHK("irq mask", 1'h0, irq)
    wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
    wr(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
    settle();
    `CHK("irq clr", 1'h0, irq)
    badMf <= 1'h0;
    frm(7);
    `CHK("lom clr", 1'h0, tug2ServerFailOut)
    $display("test loss done");
    l = 3'($urandom_range(6));
    if (l > 3'h3) l++;
    lbl <= l;
    frm(8);
    `CHK("tu3 plm", 1'h1, tu3ServerFailOut)
    rdc("plm st", ADDR_STATUS, st(1, 0, 1, l));
    incomingTrailFail <= 1'h1;
    settle();
    rdc("tsf st", ADDR_STATUS, st(0, 0, 1, l));
    `CHK("tu3 tsf", 1'h1, tu3ServerFailOut)
    incomingTrailFail <= 1'h0;
    badMf <= 1'h1;
    frm(11);
    rdc("plm lom", ADDR_STATUS, st(1, 0, 0, l));
    lbl <= 3'h4;
    badMf <= 1'h0;
    frm(8);
    `CHK("tu3 back", 1'h0, tu3ServerFailOut)
    $display("test label done");
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    settle();
    `CHK("tu3 off", 1'h1, tu3ServerFailOut)
    `CHK("tug2 off", 1'h1, tug2ServerFailOut)
    rdc("st off", ADDR_STATUS, 32'h0);
    for (int i = 0; i < 16; i++) begin
      {m, l, k} = 7'($urandom);
      if (i == 0) {m, l, k} = {TU12_MAX, TUG2_MAX_C, TUG3_C};
      if (i == 1) {m, l, k} = {TU12_MIN, 3'h6, TUG3_C};
      wr(ADDR_SINK_SEL, {25'h0, m, l, k}, RESP_OKAY);
      rdc("sel", ADDR_SINK_SEL, {23'h0, ok3(k, l, m), 1'h0, m, l, k});
      `CHK("sel ok", ok3(k, l, m), loSinkValid)
      `CHK("sel", {m, l, k}, {loSinkTu12, loSinkTug2, loSinkTug3})
    end
    $display("test selector done");
    run <= 1'h0;
    end_sim();
  end
endmodule : test_p4t_tug3_adaptation_sink

bind p4t_tug3_adaptation_sink p4t_sink_properties #(.LOM_CNT(LOM_CNT))
  i_chk (.sys_clk, .srst, .p4sData, .tug3Data, .tug3FrameStart,
  .multiframeStartOut, .tu3ServerFailOut, .tug2ServerFailOut,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// File: src/p4t_pkg.sv
// Purpose: Shared constants and types for the path-to-TUG-3 sink adaptation
// Assumes: AXI4-Lite with 32-bit data, byte addresses on word boundaries
// Notes:   All offsets, field positions and codes live here except OH_POS, a module parameter
`default_nettype none
package p4t_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_SINK_SEL = 8'h10;
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;
  // Bus responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Control and status fields
  localparam int         CTRL_ACTIVE   = 0;
  localparam logic       CTRL_RST      = 1'h0;
  localparam int         ST_PLM        = 0;
  localparam int         ST_LOM        = 1;
  localparam int         ST_INMF       = 2;
  localparam int         ST_LBL_LO     = 4;
  localparam int         ST_LBL_HI     = 6;
  // Interrupt bit layout (status and mask)
  localparam int         IRQ_PLM       = 0;
  localparam int         IRQ_LOM       = 1;
  localparam int         IRQ_W         = 2;
  // Sink selector fields
  localparam int         SEL_K_LO      = 0;
  localparam int         SEL_K_HI      = 1;
  localparam int         SEL_L_LO      = 2;
  localparam int         SEL_L_HI      = 4;
  localparam int         SEL_M_LO      = 5;
  localparam int         SEL_M_HI      = 6;
  localparam int         SEL_VALID     = 8;
  localparam logic [1:0] TUG3_A        = 2'h0;
  localparam logic [1:0] TUG3_C        = 2'h2;
  localparam logic [2:0] TUG2_MIN      = 3'h1;
  localparam logic [2:0] TUG2_MAX_AB   = 3'h7;
  localparam logic [2:0] TUG2_MAX_C    = 3'h5;
  localparam logic [1:0] TU12_MIN      = 2'h1;
  localparam logic [1:0] TU12_MAX      = 2'h3;
  // Overhead byte layout, first received bit is bit 1 at position 7
  localparam int         OH_LBL_HI     = 5;
  localparam int         OH_LBL_LO     = 3;
  localparam int         OH_MF_HI      = 2;
  localparam int         OH_MF_LO      = 1;
  localparam int         OH_BITS       = 8;
  localparam logic [2:0] LABEL_EXPECTED = 3'h4;
  localparam logic [1:0] MF_CODE_LAST  = 2'h0;
  localparam logic [1:0] MF_CODE_STEP  = 2'h1;
  localparam logic [2:0] MF_ALIGN_FRAMES = 3'h4;
  // Timing
  localparam int         CLK_MHZ       = 200;
  localparam int         LOM_TIME_US   = 3000;
  localparam int         LOM_CYCLES    = LOM_TIME_US * CLK_MHZ;
  // Multiframe alignment states
  typedef enum logic {MF_OUT, MF_IN} p4t_mf_state_t;
endpackage : p4t_pkg
`default_nettype wire

// File: src/p4t_tug3_adaptation_sink.sv
// Purpose: Path payload to TUG-3 sink adaptation with label and multiframe
// Assumes: Link clock well below sys_clk; it is sampled, not used as clock
// Notes:   Registers over AXI4-Lite; one level interrupt
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module p4t_tug3_adaptation_sink #(
  parameter int LOM_CNT    = p4t_pkg::LOM_CYCLES,
  parameter int ACCEPT_FRM = 5,
  parameter int OH_POS     = 16,
  parameter int CNT_W      = 16
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  // Incoming path stream (asynchronous pins)
  input  wire logic                        p4sClk,
  input  wire logic                        p4sData,
  input  wire logic                        p4sFrameStart,
  input  wire logic                        incomingTrailFail,
  // Outgoing TUG-3 stream
  output logic                             tug3Clk,
  output logic                             tug3Data,
  output logic                             tug3FrameStart,
  output logic                             multiframeStartOut,
  output logic                             tu3ServerFailOut,
  output logic                             tug2ServerFailOut,
  // Lower-order sink selector
  output logic [1:0]                       loSinkTug3,
  output logic [2:0]                       loSinkTug2,
  output logic [1:0]                       loSinkTu12,
  output logic                             loSinkValid,
  // AXI4-Lite slave
  input  wire logic [p4t_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [p4t_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [p4t_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [p4t_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Interrupt
  output logic                             irq
);
  import p4t_pkg::*;

  localparam int LT_W = $clog2(LOM_CNT + 1);

  // Elaboration checks
  if (ACCEPT_FRM < 1 || ACCEPT_FRM > 15) begin : g_chk_acc
    $error("ACCEPT_FRM must be 1 to 15");
  end
  if (LOM_CNT < 1 || OH_POS + OH_BITS >= (1 << CNT_W)) begin : g_chk_cnt
    $error("LOM_CNT or OH_POS out of range");
  end

  // Two-stage synchronisers for the four pins
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic       clkPrev_reg;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      syncA_reg   <= 4'h0;
      syncB_reg   <= 4'h0;
      clkPrev_reg <= 1'b0;
    end else begin
      syncA_reg   <= {incomingTrailFail, p4sFrameStart, p4sData, p4sClk};
      syncB_reg   <= syncA_reg;
      clkPrev_reg <= syncB_reg[0];
    end
  end
  logic linkRise;
  logic dataBit;
  logic fsBit;
  logic tsfBit;
  assign linkRise = syncB_reg[0] & ~clkPrev_reg;
  assign dataBit  = syncB_reg[1];
  assign fsBit    = syncB_reg[2];
  assign tsfBit   = syncB_reg[3];

  // Framing, alignment, label acceptance and loss timer state
  logic [CNT_W-1:0] bitCnt_reg, bitCnt_next;
  logic [7:0]       shift_reg, shift_next;
  logic [1:0]       mfCode_reg, mfCode_next;
  p4t_mf_state_t    mfState_reg, mfState_next;
  logic [2:0]       alignCnt_reg, alignCnt_next;
  logic [2:0]       lblCand_reg, lblCand_next;
  logic [3:0]       lblCnt_reg, lblCnt_next;
  logic [2:0]       lblAcc_reg, lblAcc_next;
  logic [LT_W-1:0]  lomTimer_reg, lomTimer_next;
  logic             lomDef_reg, lomDef_next;
  logic             mfsPulse_next;
  logic             active;
  logic             plmDef;

  // Next state; the overhead byte is evaluated when its last bit arrives
  always_comb begin
    logic [CNT_W-1:0] idx;
    logic [7:0]       ohByte;
    logic [3:0]       cntInc;
    idx           = '0;
    ohByte        = '0;
    cntInc        = '0;
    bitCnt_next   = bitCnt_reg;
    shift_next    = shift_reg;
    mfCode_next   = mfCode_reg;
    mfState_next  = mfState_reg;
    alignCnt_next = alignCnt_reg;
    lblCand_next  = lblCand_reg;
    lblCnt_next   = lblCnt_reg;
    lblAcc_next   = lblAcc_reg;
    mfsPulse_next = 1'b0;
    if (linkRise) begin
      idx = fsBit ? '0 : bitCnt_reg;
      if (idx != '1) begin
        bitCnt_next = idx + 1'b1;
      end
      // Start of the frame after the one carrying code 00 begins a multiframe
      if (fsBit && mfState_reg == MF_IN && mfCode_reg == MF_CODE_LAST) begin
        mfsPulse_next = 1'b1;
      end
      if (idx >= CNT_W'(OH_POS) && idx < CNT_W'(OH_POS + OH_BITS)) begin
        ohByte     = {shift_reg[6:0], dataBit};
        shift_next = ohByte;
      end
      if (idx == CNT_W'(OH_POS + OH_BITS - 1)) begin
        mfCode_next = ohByte[OH_MF_HI:OH_MF_LO];
        case (mfState_reg)
          MF_IN: begin
            if (ohByte[OH_MF_HI:OH_MF_LO] != mfCode_reg + MF_CODE_STEP) begin
              mfState_next  = MF_OUT;
              alignCnt_next = '0;
            end
          end
          MF_OUT: begin
            if (ohByte[OH_MF_HI:OH_MF_LO] == mfCode_reg + MF_CODE_STEP) begin
              if (alignCnt_reg == MF_ALIGN_FRAMES - 3'h1) begin
                mfState_next  = MF_IN;
                alignCnt_next = '0;
              end else begin
                alignCnt_next = alignCnt_reg + 3'h1;
              end
            end else begin
              alignCnt_next = '0;
            end
          end
          default: begin
            mfState_next  = MF_OUT;
            alignCnt_next = '0;
          end
        endcase
        // Label is accepted after ACCEPT_FRM identical frames
        cntInc = (lblCnt_reg == 4'hf) ? lblCnt_reg : lblCnt_reg + 4'h1;
        if (ohByte[OH_LBL_HI:OH_LBL_LO] == lblCand_reg) begin
          lblCnt_next = cntInc;
        end else begin
          lblCand_next = ohByte[OH_LBL_HI:OH_LBL_LO];
          lblCnt_next  = '0;
        end
        if (lblCnt_next == 4'(ACCEPT_FRM - 1)) begin
          lblAcc_next = ohByte[OH_LBL_HI:OH_LBL_LO];
        end
      end
    end
    // Loss timer runs only while out of alignment
    if (mfState_reg == MF_IN) begin
      lomTimer_next = '0;
      lomDef_next   = 1'b0;
    end else if (lomTimer_reg == LT_W'(LOM_CNT - 1)) begin
      lomTimer_next = lomTimer_reg;
      lomDef_next   = 1'b1;
    end else begin
      lomTimer_next = lomTimer_reg + 1'b1;
      lomDef_next   = lomDef_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bitCnt_reg   <= '1;
      shift_reg    <= '0;
      mfCode_reg   <= MF_CODE_LAST;
      mfState_reg  <= MF_OUT;
      alignCnt_reg <= '0;
      lblCand_reg  <= LABEL_EXPECTED;
      lblCnt_reg   <= '0;
      lblAcc_reg   <= LABEL_EXPECTED;
      lomTimer_reg <= '0;
      lomDef_reg   <= 1'b0;
    end else begin
      bitCnt_reg   <= bitCnt_next;
      shift_reg    <= shift_next;
      mfCode_reg   <= mfCode_next;
      mfState_reg  <= mfState_next;
      alignCnt_reg <= alignCnt_next;
      lblCand_reg  <= lblCand_next;
      lblCnt_reg   <= lblCnt_next;
      lblAcc_reg   <= lblAcc_next;
      lomTimer_reg <= lomTimer_next;
      lomDef_reg   <= lomDef_next;
    end
  end

  assign plmDef = (lblAcc_reg != LABEL_EXPECTED);

  // Registers: control, causes, interrupts, selector
  logic              ctrlActive_reg, ctrlActive_next;
  logic              plmCause_reg, plmCause_next;
  logic              lomCause_reg, lomCause_next;
  logic [IRQ_W-1:0]  irqStat_reg, irqStat_next;
  logic [IRQ_W-1:0]  irqMask_reg, irqMask_next;
  logic [6:0]        sinkSel_reg, sinkSel_next;
  logic              sinkOk_next;
  logic              doWrite;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [DATA_W-1:0] wData_reg;
  logic [3:0]        wStrb_reg;
  assign active = ctrlActive_reg;

  // Fault causes are hidden while inactive; event bits win over clears
  always_comb begin
    logic [IRQ_W-1:0] rise;
    logic [IRQ_W-1:0] clr;
    logic [1:0]       k;
    logic [2:0]       l;
    logic [1:0]       m;
    ctrlActive_next = ctrlActive_reg;
    irqMask_next    = irqMask_reg;
    sinkSel_next    = sinkSel_reg;
    clr             = '0;
    plmCause_next   = active & plmDef & ~tsfBit;
    lomCause_next   = active & lomDef_reg & ~tsfBit & ~plmDef;
    rise            = '0;
    rise[IRQ_PLM]   = plmCause_next & ~plmCause_reg;
    rise[IRQ_LOM]   = lomCause_next & ~lomCause_reg;
    if (doWrite && wStrb_reg[0]) begin
      case (awAddr_reg)
        ADDR_CTRL:     ctrlActive_next = wData_reg[CTRL_ACTIVE];
        ADDR_IRQ_STAT: clr = wData_reg[IRQ_W-1:0];
        ADDR_IRQ_MASK: irqMask_next = wData_reg[IRQ_W-1:0];
        ADDR_SINK_SEL: sinkSel_next = wData_reg[SEL_M_HI:SEL_K_LO];
        default:       clr = '0;
      endcase
    end
    irqStat_next = (irqStat_reg & ~clr) | rise;
    // Triplet legality depends on which TUG-3 is addressed
    k = sinkSel_next[SEL_K_HI:SEL_K_LO];
    l = sinkSel_next[SEL_L_HI:SEL_L_LO];
    m = sinkSel_next[SEL_M_HI:SEL_M_LO];
    sinkOk_next = (k <= TUG3_C) && (l >= TUG2_MIN) && (m >= TU12_MIN) &&
                  (m <= TU12_MAX) &&
                  (l <= ((k == TUG3_C) ? TUG2_MAX_C : TUG2_MAX_AB));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlActive_reg <= CTRL_RST;
      plmCause_reg   <= 1'b0;
      lomCause_reg   <= 1'b0;
      irqStat_reg    <= '0;
      irqMask_reg    <= '0;
      sinkSel_reg    <= '0;
      loSinkValid    <= 1'b0;
      irq            <= 1'b0;
    end else begin
      ctrlActive_reg <= ctrlActive_next;
      plmCause_reg   <= plmCause_next;
      lomCause_reg   <= lomCause_next;
      irqStat_reg    <= irqStat_next;
      irqMask_reg    <= irqMask_next;
      sinkSel_reg    <= sinkSel_next;
      loSinkValid    <= sinkOk_next;
      irq            <= |(irqStat_next & irqMask_next);
    end
  end
  assign loSinkTug3 = sinkSel_reg[SEL_K_HI:SEL_K_LO];
  assign loSinkTug2 = sinkSel_reg[SEL_L_HI:SEL_L_LO];
  assign loSinkTu12 = sinkSel_reg[SEL_M_HI:SEL_M_LO];

  // Stream outputs; pass-through costs three cycles of sys_clk latency
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tug3Clk            <= 1'b0;
      tug3Data           <= 1'b0;
      tug3FrameStart     <= 1'b0;
      multiframeStartOut <= 1'b0;
      tu3ServerFailOut   <= 1'b1;
      tug2ServerFailOut  <= 1'b1;
    end else begin
      tug3Clk            <= syncB_reg[0];
      tug3Data           <= dataBit;
      tug3FrameStart     <= fsBit;
      multiframeStartOut <= mfsPulse_next;
      tu3ServerFailOut   <= ~active | plmDef;
      tug2ServerFailOut  <= ~active | plmDef | lomDef_reg;
    end
  end

  // AXI4-Lite: address and data taken in any order, response after both
  logic awHeld_reg, awHeld_next;
  logic wHeld_reg, wHeld_next;
  logic bvalid_next;
  logic rvalid_next;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0]        bresp_next, rresp_next;
  logic [ADDR_W-1:0] awAddr_next;
  logic [DATA_W-1:0] wData_next;
  logic [3:0]        wStrb_next;
  assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next  = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rdata_next  = s_axi_rdata;
    rresp_next  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bvalid_next = 1'b1;
      case (awAddr_reg)
        ADDR_CTRL, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
        ADDR_SINK_SEL: bresp_next = RESP_OKAY;
        default:       bresp_next = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_next[CTRL_ACTIVE] = ctrlActive_reg;
        ADDR_STATUS: begin
          rdata_next[ST_PLM]  = plmCause_reg;
          rdata_next[ST_LOM]  = lomCause_reg;
          rdata_next[ST_INMF] = active & (mfState_reg == MF_IN);
          rdata_next[ST_LBL_HI:ST_LBL_LO] = active ? lblAcc_reg : '0;
        end
        ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0] = irqStat_reg;
        ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irqMask_reg;
        ADDR_SINK_SEL: begin
          rdata_next[SEL_M_HI:SEL_K_LO] = sinkSel_reg;
          rdata_next[SEL_VALID]         = loSinkValid;
        end
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= '0;
      wData_reg     <= '0;
      wStrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      awHeld_reg    <= awHeld_next;
      wHeld_reg     <= wHeld_next;
      awAddr_reg    <= awAddr_next;
      wData_reg     <= wData_next;
      wStrb_reg     <= wStrb_next;
      s_axi_awready <= ~awHeld_next & ~bvalid_next;
      s_axi_wready  <= ~wHeld_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end
  end
endmodule : p4t_tug3_adaptation_sink
`default_nettype wire
